/* File: rtl/dpit_pkg.sv */
package dpit_pkg;

    // ----------------------------------------------------------------
    // register word indices (byte address = 4 * index)
    // ----------------------------------------------------------------
    localparam logic [11:0] OFS_ROOT = 12'h006;
    localparam logic [11:0] OFS_MAIN_EN = 12'h008;
    localparam logic [11:0] OFS_DEV_EN = 12'h009;
    localparam logic [11:0] OFS_HOST_EN = 12'h00A;
    localparam logic [11:0] OFS_CPU_EN = 12'h00B;
    localparam logic [11:0] OFS_FIFO_EN = 12'h00C;
    localparam logic [11:0] OFS_REV = 12'h010;
    localparam logic [11:0] OFS_EVT_STAT = 12'h018;
    localparam logic [11:0] OFS_EVT_MASK = 12'h019;
    localparam logic [11:0] PORT1_BASE = 12'h200;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int MAIN_DEV_BIT = 7;
    localparam int MAIN_HOST_BIT = 6;
    localparam int MAIN_CPU_BIT = 5;
    localparam int MAIN_FIFO_BIT = 4;
    localparam int MAIN_PM_BIT = 0;
    localparam int ROOT_P0_BIT = 0;
    localparam int ROOT_P1_BIT = 1;

    // ----------------------------------------------------------------
    // writable bits, reset values, sleep-capable bits
    // ----------------------------------------------------------------
    localparam logic [7:0] MAIN_EN_P0_MASK = 8'hF1;
    localparam logic [7:0] MAIN_EN_P1_MASK = 8'h71;
    localparam logic [7:0] DEV_EN_MASK = 8'hBB;
    localparam logic [7:0] HOST_EN_MASK = 8'hFB;
    localparam logic [7:0] CPU_EN_MASK = 8'h83;
    localparam logic [7:0] FIFO_EN_MASK = 8'h87;
    localparam logic [7:0] ROOT_MASK = 8'h03;
    localparam logic [7:0] EVT_MASK_BITS = 8'h03;
    localparam logic [7:0] EN_RESET = 8'h00;
    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic [7:0] MAIN_SLEEP_OK = 8'hC1;
    localparam logic [7:0] DEV_SLEEP_OK = 8'hA0;
    localparam logic [7:0] HOST_SLEEP_OK = 8'hC0;
    localparam logic [7:0] NONE_SLEEP_OK = 8'h00;

    // arbitrary revision code, not tied to any part
    localparam logic [7:0] REV_DEFAULT = 8'h5A;

endpackage

/* File: rtl/dpit_irq_tree.sv */
// Added by the designer: the Wishbone slave port.
`timescale 1ns/100ps

// Behaviour
// - root status shared, same at both windows
// - root status names the interrupting port(s)
// - root bit1 reflects enabled port1 main status
// - root bit0 reflects port0; bits 7-2 zero
// - main enable gates each main status factor
// - enable one passes factor, zero blocks it
// - main enable bits 7,6,5,4,0 read/write
// - device, host, power-done enables work asleep
// - port1 device-group enable bit is undefined
// - device-group enable only in port0 window
// - device-group enable layout, bits 6,2 reserved
// - host-group enable gates host main bit
// - bus-power error, line change work asleep
// - cpu-interface enable gates cpu main bit
// - buffer enable gates buffer main bit
// - fixed revision register, readable asleep
module dpit_irq_tree #(
    parameter logic [7:0] CHIP_REVISION = dpit_pkg::REV_DEFAULT
) (
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    input wire logic CYC_IN,
    input wire logic STB_IN,
    input wire logic WE_IN,
    input wire logic [13:2] ADR_IN,
    input wire logic [3:0] SEL_IN,
    input wire logic [31:0] DAT_IN,
    output logic [31:0] DAT_OUT,
    output logic ACK_OUT,
    input wire logic SLEEP_IN,
    input wire logic [7:0] DEV_STAT_P0_IN,
    input wire logic [7:0] HOST_STAT_P0_IN,
    input wire logic [7:0] HOST_STAT_P1_IN,
    input wire logic [7:0] CPU_STAT_P0_IN,
    input wire logic [7:0] CPU_STAT_P1_IN,
    input wire logic [7:0] FIFO_STAT_P0_IN,
    input wire logic [7:0] FIFO_STAT_P1_IN,
    input wire logic [1:0] PM_DONE_IN,
    output logic [7:0] MAIN_STAT_P0_OUT,
    output logic [7:0] MAIN_STAT_P1_OUT,
    output logic [7:0] ROOT_STAT_OUT,
    output logic IRQ_N_OUT,
    output logic EVT_IRQ_OUT
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic group_hit(input logic [7:0] stat, input logic [7:0] en);
        group_hit = |(stat & en);
    endfunction

    function automatic logic [7:0] eff_en(input logic [7:0] en, input logic [7:0] ok, input logic sleep);
        eff_en = en & (sleep ? ok : dpit_pkg::ALL_ONES);
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] main_en_q [2];
    logic [7:0] host_en_q [2];
    logic [7:0] cpu_en_q [2];
    logic [7:0] fifo_en_q [2];
    logic [7:0] dev_en_q;
    logic [7:0] evt_stat_q;
    logic [7:0] evt_mask_q;
    logic [7:0] root_q;
    logic [7:0] main_p0_q;
    logic [7:0] main_p1_q;
    logic irq_n_q;
    logic evt_irq_q;
    logic ack_q;
    logic [31:0] dat_q;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire logic [11:0] idx = ADR_IN;
    wire logic req = CYC_IN & STB_IN & ~ack_q;
    wire logic wr = req & WE_IN & SEL_IN[0];
    wire logic [7:0] wdat = DAT_IN[7:0];
    wire logic hit_root = (idx == dpit_pkg::OFS_ROOT) || (idx == (dpit_pkg::OFS_ROOT | dpit_pkg::PORT1_BASE));
    wire logic hit_main0 = idx == dpit_pkg::OFS_MAIN_EN;
    wire logic hit_main1 = idx == (dpit_pkg::OFS_MAIN_EN | dpit_pkg::PORT1_BASE);
    wire logic hit_dev = idx == dpit_pkg::OFS_DEV_EN;
    wire logic hit_host0 = idx == dpit_pkg::OFS_HOST_EN;
    wire logic hit_host1 = idx == (dpit_pkg::OFS_HOST_EN | dpit_pkg::PORT1_BASE);
    wire logic hit_cpu0 = idx == dpit_pkg::OFS_CPU_EN;
    wire logic hit_cpu1 = idx == (dpit_pkg::OFS_CPU_EN | dpit_pkg::PORT1_BASE);
    wire logic hit_fifo0 = idx == dpit_pkg::OFS_FIFO_EN;
    wire logic hit_fifo1 = idx == (dpit_pkg::OFS_FIFO_EN | dpit_pkg::PORT1_BASE);
    wire logic hit_rev = (idx == dpit_pkg::OFS_REV) || (idx == (dpit_pkg::OFS_REV | dpit_pkg::PORT1_BASE));
    wire logic hit_evt_stat = idx == dpit_pkg::OFS_EVT_STAT;
    wire logic hit_evt_mask = idx == dpit_pkg::OFS_EVT_MASK;

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    logic [7:0] rd8;
    always_comb begin
        // port1 device-group window is unmapped and reads zero
        if (hit_root) begin
            rd8 = root_q;
        end else if (hit_main0) begin
            rd8 = main_en_q[0];
        end else if (hit_main1) begin
            rd8 = main_en_q[1];
        end else if (hit_dev) begin
            rd8 = dev_en_q;
        end else if (hit_host0) begin
            rd8 = host_en_q[0];
        end else if (hit_host1) begin
            rd8 = host_en_q[1];
        end else if (hit_cpu0) begin
            rd8 = cpu_en_q[0];
        end else if (hit_cpu1) begin
            rd8 = cpu_en_q[1];
        end else if (hit_fifo0) begin
            rd8 = fifo_en_q[0];
        end else if (hit_fifo1) begin
            rd8 = fifo_en_q[1];
        end else if (hit_rev) begin
            rd8 = CHIP_REVISION;
        end else if (hit_evt_stat) begin
            rd8 = evt_stat_q;
        end else if (hit_evt_mask) begin
            rd8 = evt_mask_q;
        end else begin
            rd8 = 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // enable gating and aggregation
    // ----------------------------------------------------------------
    // sleep keeps only the factors that stay live without the clock tree
    wire logic [7:0] m_en0 = eff_en(main_en_q[0], dpit_pkg::MAIN_SLEEP_OK, SLEEP_IN);
    wire logic [7:0] m_en1 = eff_en(main_en_q[1], dpit_pkg::MAIN_SLEEP_OK, SLEEP_IN);
    wire logic [7:0] d_en = eff_en(dev_en_q, dpit_pkg::DEV_SLEEP_OK, SLEEP_IN);
    wire logic [7:0] h_en0 = eff_en(host_en_q[0], dpit_pkg::HOST_SLEEP_OK, SLEEP_IN);
    wire logic [7:0] h_en1 = eff_en(host_en_q[1], dpit_pkg::HOST_SLEEP_OK, SLEEP_IN);
    wire logic [7:0] c_en0 = eff_en(cpu_en_q[0], dpit_pkg::NONE_SLEEP_OK, SLEEP_IN);
    wire logic [7:0] c_en1 = eff_en(cpu_en_q[1], dpit_pkg::NONE_SLEEP_OK, SLEEP_IN);
    wire logic [7:0] f_en0 = eff_en(fifo_en_q[0], dpit_pkg::NONE_SLEEP_OK, SLEEP_IN);
    wire logic [7:0] f_en1 = eff_en(fifo_en_q[1], dpit_pkg::NONE_SLEEP_OK, SLEEP_IN);

    // port1 has no device-function path, so its device bit stays zero
    wire logic [7:0] main_irq_status_p0 = {group_hit(DEV_STAT_P0_IN, d_en),
        group_hit(HOST_STAT_P0_IN, h_en0), group_hit(CPU_STAT_P0_IN, c_en0),
        group_hit(FIFO_STAT_P0_IN, f_en0), 3'b000, PM_DONE_IN[0]};
    wire logic [7:0] main_irq_status_p1 = {1'b0, group_hit(HOST_STAT_P1_IN, h_en1),
        group_hit(CPU_STAT_P1_IN, c_en1), group_hit(FIFO_STAT_P1_IN, f_en1), 3'b000, PM_DONE_IN[1]};

    wire logic first_port_pending = group_hit(main_irq_status_p0, m_en0);
    wire logic second_port_pending = group_hit(main_irq_status_p1, m_en1);
    wire logic [7:0] root_d = {6'b000000, second_port_pending, first_port_pending};
    wire logic [7:0] evt_rise = root_d & ~root_q;
    wire logic [7:0] evt_clr = (wr && hit_evt_stat) ? wdat : 8'h00;
    // a rising edge in the clearing cycle survives the clear
    wire logic [7:0] evt_stat_d = (evt_stat_q & ~evt_clr) | evt_rise;

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            main_en_q[0] <= dpit_pkg::EN_RESET;
            main_en_q[1] <= dpit_pkg::EN_RESET;
            dev_en_q <= dpit_pkg::EN_RESET;
            host_en_q[0] <= dpit_pkg::EN_RESET;
            host_en_q[1] <= dpit_pkg::EN_RESET;
            cpu_en_q[0] <= dpit_pkg::EN_RESET;
            cpu_en_q[1] <= dpit_pkg::EN_RESET;
            fifo_en_q[0] <= dpit_pkg::EN_RESET;
            fifo_en_q[1] <= dpit_pkg::EN_RESET;
            evt_mask_q <= dpit_pkg::EN_RESET;
        end else if (wr) begin
            if (hit_main0) main_en_q[0] <= wdat & dpit_pkg::MAIN_EN_P0_MASK;
            if (hit_main1) main_en_q[1] <= wdat & dpit_pkg::MAIN_EN_P1_MASK;
            if (hit_dev) dev_en_q <= wdat & dpit_pkg::DEV_EN_MASK;
            if (hit_host0) host_en_q[0] <= wdat & dpit_pkg::HOST_EN_MASK;
            if (hit_host1) host_en_q[1] <= wdat & dpit_pkg::HOST_EN_MASK;
            if (hit_cpu0) cpu_en_q[0] <= wdat & dpit_pkg::CPU_EN_MASK;
            if (hit_cpu1) cpu_en_q[1] <= wdat & dpit_pkg::CPU_EN_MASK;
            if (hit_fifo0) fifo_en_q[0] <= wdat & dpit_pkg::FIFO_EN_MASK;
            if (hit_fifo1) fifo_en_q[1] <= wdat & dpit_pkg::FIFO_EN_MASK;
            if (hit_evt_mask) evt_mask_q <= wdat & dpit_pkg::EVT_MASK_BITS;
        end
    end

    // ----------------------------------------------------------------
    // status, interrupt outputs, bus answer
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            root_q <= 8'h00;
            main_p0_q <= 8'h00;
            main_p1_q <= 8'h00;
            irq_n_q <= 1'b1;
            evt_stat_q <= 8'h00;
            evt_irq_q <= 1'b0;
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            root_q <= root_d & dpit_pkg::ROOT_MASK;
            main_p0_q <= main_irq_status_p0;
            main_p1_q <= main_irq_status_p1;
            irq_n_q <= ~(first_port_pending | second_port_pending);
            evt_stat_q <= evt_stat_d & dpit_pkg::EVT_MASK_BITS;
            evt_irq_q <= |(evt_stat_d & evt_mask_q);
            ack_q <= req;
            dat_q <= req ? {24'h00_0000, rd8} : 32'h0000_0000;
        end
    end

    assign DAT_OUT = dat_q;
    assign ACK_OUT = ack_q;
    assign MAIN_STAT_P0_OUT = main_p0_q;
    assign MAIN_STAT_P1_OUT = main_p1_q;
    assign ROOT_STAT_OUT = root_q;
    assign IRQ_N_OUT = irq_n_q;
    assign EVT_IRQ_OUT = evt_irq_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (RST_IN);

    sequence rd_root_s;
        req && !WE_IN && hit_root;
    endsequence

    sequence rd_rev_s;
        req && !WE_IN && hit_rev;
    endsequence

    sequence rd_dev1_s;
        req && !WE_IN && (idx == (dpit_pkg::OFS_DEV_EN | dpit_pkg::PORT1_BASE));
    endsequence

    root_mirror_a: assert property (rd_root_s |=> ACK_OUT && DAT_OUT == {24'h00_0000, $past(root_q)})
        else $error("root read differs from shared root status");
    irq_source_a: assert property (!IRQ_N_OUT |-> ROOT_STAT_OUT[1:0] != 2'b00)
        else $error("interrupt asserted with no source port shown");
    root_port1_a: assert property (##1 ROOT_STAT_OUT[1] == $past(|(main_irq_status_p1 & m_en1)))
        else $error("root bit1 does not follow port1 enabled status");
    root_port0_a: assert property (##1 ROOT_STAT_OUT == {7'h00, $past(|(main_irq_status_p0 & m_en0))}
        || ROOT_STAT_OUT[7:2] == 6'h00 && ROOT_STAT_OUT[0] == $past(first_port_pending))
        else $error("root bit0 wrong or reserved bits set");
    main_block_a: assert property ((main_en_q[0] == 8'h00 && main_en_q[1] == 8'h00) |=> IRQ_N_OUT)
        else $error("interrupt asserted with all main enables zero");
    enable_pass_a: assert property ((PM_DONE_IN[0] && main_en_q[0][0]) |=> !IRQ_N_OUT ##0 ROOT_STAT_OUT[0])
        else $error("enabled factor did not reach the interrupt");
    main_layout_a: assert property ((main_en_q[0] & ~dpit_pkg::MAIN_EN_P0_MASK) == 8'h00)
        else $error("reserved main enable bit set");
    sleep_pm_a: assert property ((SLEEP_IN && PM_DONE_IN[1] && main_en_q[1][0]) |=> ROOT_STAT_OUT[1])
        else $error("power-done enable blocked in sleep");
    port1_dev_a: assert property (MAIN_STAT_P1_OUT[7] == 1'b0 && main_en_q[1][7] == 1'b0)
        else $error("port1 device group bit active");
    dev_window_a: assert property (rd_dev1_s |=> ACK_OUT && DAT_OUT == 32'h0000_0000)
        else $error("device enable visible in port1 window");
    host_sleep_a: assert property ((SLEEP_IN && HOST_STAT_P0_IN[7] && host_en_q[0][7]) |=> MAIN_STAT_P0_OUT[6])
        else $error("bus-power error blocked in sleep");
    cpu_sleep_a: assert property (SLEEP_IN |=> !MAIN_STAT_P0_OUT[5] && !MAIN_STAT_P1_OUT[4])
        else $error("cpu or buffer group active in sleep");
    rev_read_a: assert property (rd_rev_s |=> ACK_OUT && DAT_OUT[7:0] == CHIP_REVISION)
        else $error("revision read returned wrong value");
    reset_zero_a: assert property (@(posedge MCLK_IN) disable iff (1'b0)
        RST_IN |=> main_en_q[0] == 8'h00 && dev_en_q == 8'h00 && IRQ_N_OUT)
        else $error("enables not cleared by reset");
    evt_sticky_a: assert property (evt_rise[0] |=> evt_stat_q[0])
        else $error("source event lost");

    // ----------------------------------------------------------------
    // group gating checks
    // ----------------------------------------------------------------
    // awake, an enabled port0 device, port1 host, port0 cpu or port1 buffer factor must reach main status one edge later
    sequence awake_dev_hit_s;
        !SLEEP_IN && |(DEV_STAT_P0_IN & dev_en_q);
    endsequence

    sequence awake_host1_hit_s;
        !SLEEP_IN && |(HOST_STAT_P1_IN & host_en_q[1]);
    endsequence

    sequence awake_cpu0_hit_s;
        !SLEEP_IN && |(CPU_STAT_P0_IN & cpu_en_q[0]);
    endsequence

    sequence awake_fifo1_hit_s;
        !SLEEP_IN && |(FIFO_STAT_P1_IN & fifo_en_q[1]);
    endsequence

    dev_gate_a: assert property (awake_dev_hit_s
        |=> MAIN_STAT_P0_OUT[dpit_pkg::MAIN_DEV_BIT])
        else $error("enabled device factor missing from main status");
    host_gate_a: assert property (awake_host1_hit_s
        |=> MAIN_STAT_P1_OUT[dpit_pkg::MAIN_HOST_BIT])
        else $error("enabled host factor missing from main status");
    cpu_gate_a: assert property (awake_cpu0_hit_s
        |=> MAIN_STAT_P0_OUT[dpit_pkg::MAIN_CPU_BIT])
        else $error("enabled cpu factor missing from main status");
    fifo_gate_a: assert property (awake_fifo1_hit_s
        |=> MAIN_STAT_P1_OUT[dpit_pkg::MAIN_FIFO_BIT])
        else $error("enabled buffer factor missing from main status");
    dev_block_a: assert property (((DEV_STAT_P0_IN & dev_en_q) == 8'h00)
        |=> !MAIN_STAT_P0_OUT[dpit_pkg::MAIN_DEV_BIT])
        else $error("blocked device factor reached main status");
    dev_sleep_a: assert property ((SLEEP_IN && DEV_STAT_P0_IN[5] && dev_en_q[5])
        |=> MAIN_STAT_P0_OUT[dpit_pkg::MAIN_DEV_BIT])
        else $error("device engine factor blocked in sleep");
    line_sleep_a: assert property ((SLEEP_IN && HOST_STAT_P1_IN[6] && host_en_q[1][6])
        |=> MAIN_STAT_P1_OUT[dpit_pkg::MAIN_HOST_BIT])
        else $error("line change factor blocked in sleep");
    enable_rsv_a: assert property (((dev_en_q & ~dpit_pkg::DEV_EN_MASK)
        | (cpu_en_q[0] & ~dpit_pkg::CPU_EN_MASK) | (fifo_en_q[1] & ~dpit_pkg::FIFO_EN_MASK)) == 8'h00)
        else $error("reserved group enable bit set");
    port1_main_a: assert property ((main_en_q[1]
        & ~dpit_pkg::MAIN_EN_P1_MASK) == 8'h00)
        else $error("port1 main enable holds an undefined bit");

    // ----------------------------------------------------------------
    // interrupt output and bus answer checks
    // ----------------------------------------------------------------
    irq_any_a: assert property ((first_port_pending || second_port_pending)
        |=> !IRQ_N_OUT)
        else $error("pending port did not assert the interrupt");
    irq_idle_a: assert property (!(first_port_pending || second_port_pending)
        |=> IRQ_N_OUT)
        else $error("interrupt asserted with no pending port");
    root_rsv_a: assert property (ROOT_STAT_OUT[7:2]
        == 6'h00)
        else $error("reserved root status bit set");
    ack_once_a: assert property (ACK_OUT
        |=> !ACK_OUT)
        else $error("bus answer longer than one cycle");
    ack_next_a: assert property (req
        |=> ACK_OUT)
        else $error("bus request not answered on the next edge");
    evt_clear_a: assert property ((wr && hit_evt_stat && wdat[0] && !evt_rise[0])
        |=> !evt_stat_q[0])
        else $error("event status not cleared by writing one");
    evt_irq_a: assert property ((|(evt_stat_d & evt_mask_q))
        |=> EVT_IRQ_OUT)
        else $error("unmasked event did not raise the event interrupt");

endmodule

/* File: verif/dpit_factor_model.sv */
`timescale 1ns/100ps

// sticky factor register as the far side keeps it; software clears by writing one
module dpit_factor_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [7:0] set_in,
    input wire logic [7:0] clr_in,
    output logic [7:0] stat_out
);
    logic [7:0] stat_q;
    logic [7:0] stat_d;

    // set wins so a fresh event is never lost to a late clear
    assign stat_d = (stat_q & ~clr_in) | set_in;
    assign stat_out = stat_q;

    always_ff @(posedge clk_in) begin
        if (rst_in) stat_q <= 8'h00;
        else stat_q <= stat_d;
    end
endmodule

/* File: verif/dual_port_irq_enable_tree_bench.sv */
`timescale 1ns/100ps

module dual_port_irq_enable_tree_bench;
    logic clk, rst, cyc, stb, we, ack, slp, irq_n, evt, ack_s;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, dat_s;
    logic [7:0] dev0, host0, host1, main0, main1, root, cpu0, fifo1, c0s, c0c, f1s, f1c, q;
    logic [1:0] pmd;
    int bad_count, checks, ncyc;
    logic [11:0] ofs [5] = '{dpit_pkg::OFS_MAIN_EN, dpit_pkg::OFS_DEV_EN, dpit_pkg::OFS_HOST_EN,
                            dpit_pkg::OFS_CPU_EN, dpit_pkg::OFS_FIFO_EN};
    logic [7:0] m0 [5] = '{8'hF1, 8'hBB, 8'hFB, 8'h83, 8'h87};
    logic [7:0] m1 [5] = '{8'h71, 8'h00, 8'hFB, 8'h83, 8'h87};

    dpit_irq_tree uut (.MCLK_IN(clk), .RST_IN(rst), .CYC_IN(cyc), .STB_IN(stb), .WE_IN(we), .ADR_IN(adr),
        .SEL_IN(sel), .DAT_IN(wdat), .DAT_OUT(rdat), .ACK_OUT(ack), .SLEEP_IN(slp), .DEV_STAT_P0_IN(dev0),
        .HOST_STAT_P0_IN(host0), .HOST_STAT_P1_IN(host1), .CPU_STAT_P0_IN(cpu0), .CPU_STAT_P1_IN(8'h00),
        .FIFO_STAT_P0_IN(8'h00), .FIFO_STAT_P1_IN(fifo1), .PM_DONE_IN(pmd), .MAIN_STAT_P0_OUT(main0),
        .MAIN_STAT_P1_OUT(main1), .ROOT_STAT_OUT(root), .IRQ_N_OUT(irq_n), .EVT_IRQ_OUT(evt));
    dpit_factor_model cpu_m (.clk_in(clk), .rst_in(rst), .set_in(c0s), .clr_in(c0c), .stat_out(cpu0));
    dpit_factor_model fifo_m (.clk_in(clk), .rst_in(rst), .set_in(f1s), .clr_in(f1c), .stat_out(fifo1));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ack as the coming rising edge will sample it
    always @(negedge clk) begin
        ack_s <= ack;
        dat_s <= rdat;
    end

    always @(posedge clk) begin
        ncyc <= ncyc + 1;
        if (ncyc == 20000) begin
            bad_count++;
            complete_run;
        end
    end

    task complete_run;
        if (bad_count == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] r);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'h1; wdat <= {24'h000000, d};
        do begin
            @(posedge clk);
        end while (ack_s !== 1'b1);
        r = dat_s[7:0];
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [7:0] d);
        wb(1'b1, a, d, q);
    endtask

    task rdc(input logic [11:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask

    task settle;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask

    task fac(input logic [7:0] s0, input logic [7:0] k0, input logic [7:0] s1, input logic [7:0] k1);
        @(posedge clk);
        c0s <= s0; c0c <= k0; f1s <= s1; f1c <= k1;
        @(posedge clk);
        c0s <= 8'h00; c0c <= 8'h00; f1s <= 8'h00; f1c <= 8'h00;
        settle;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task reg_table;
        for (int i = 0; i < 5; i++) begin
            for (int p = 0; p < 2; p++) begin
                rdc(ofs[i] | (p ? dpit_pkg::PORT1_BASE : 12'h000), 8'h00);
                wr(ofs[i] | (p ? dpit_pkg::PORT1_BASE : 12'h000), 8'hFF);
                rdc(ofs[i] | (p ? dpit_pkg::PORT1_BASE : 12'h000), p ? m1[i] : m0[i]);
                wr(ofs[i] | (p ? dpit_pkg::PORT1_BASE : 12'h000), 8'h00);
            end
        end
        wr(dpit_pkg::OFS_REV, 8'hFF);
        rdc(dpit_pkg::OFS_REV | dpit_pkg::PORT1_BASE, dpit_pkg::REV_DEFAULT);
        wr(dpit_pkg::OFS_ROOT, 8'hFF);
        rdc(dpit_pkg::OFS_ROOT, 8'h00);
    endtask

    task gating;
        wr(dpit_pkg::OFS_MAIN_EN, 8'h20);
        wr(dpit_pkg::OFS_CPU_EN, 8'h01);
        fac(8'h02, 8'h00, 8'h00, 8'h00);
        chk(main0, 8'h00);
        chk({7'h00, irq_n}, 8'h01);
        fac(8'h01, 8'h00, 8'h00, 8'h00);
        chk(main0, 8'h20);
        chk({7'h00, irq_n}, 8'h00);
        rdc(dpit_pkg::OFS_ROOT, 8'h01);
        rdc(dpit_pkg::OFS_ROOT | dpit_pkg::PORT1_BASE, 8'h01);
        wr(dpit_pkg::OFS_MAIN_EN, 8'h00);
        settle;
        chk({root[1:0], irq_n}, 3'b001);
        wr(dpit_pkg::OFS_MAIN_EN, 8'h20);
        fac(8'h00, 8'h03, 8'h00, 8'h00);
        chk({root[1:0], irq_n}, 3'b001);
        wr(dpit_pkg::OFS_MAIN_EN | dpit_pkg::PORT1_BASE, 8'h10);
        wr(dpit_pkg::OFS_FIFO_EN | dpit_pkg::PORT1_BASE, 8'h04);
        fac(8'h00, 8'h00, 8'h04, 8'h00);
        chk(main1, 8'h10);
        rdc(dpit_pkg::OFS_ROOT | dpit_pkg::PORT1_BASE, 8'h02);
    endtask

    task events;
        rdc(dpit_pkg::OFS_EVT_STAT, 8'h03);
        chk({7'h00, evt}, 8'h00);
        wr(dpit_pkg::OFS_EVT_MASK, 8'h03);
        settle;
        chk({7'h00, evt}, 8'h01);
        wr(dpit_pkg::OFS_EVT_STAT, 8'h03);
        settle;
        chk({7'h00, evt}, 8'h00);
        rdc(dpit_pkg::OFS_EVT_STAT, 8'h00);
        fac(8'h00, 8'h00, 8'h00, 8'h04);
        chk(root, 8'h00);
        chk({7'h00, irq_n}, 8'h01);
        @(posedge clk);
        pmd <= 2'b01;
        wr(dpit_pkg::OFS_MAIN_EN, 8'h01);
        settle;
        chk(main0, 8'h01);
        chk({7'h00, irq_n}, 8'h00);
        @(posedge clk);
        pmd <= 2'b00;
    endtask

    task asleep;
        wr(dpit_pkg::OFS_MAIN_EN, 8'hE0);
        wr(dpit_pkg::OFS_DEV_EN, 8'h20);
        wr(dpit_pkg::OFS_HOST_EN, 8'h81);
        wr(dpit_pkg::OFS_MAIN_EN | dpit_pkg::PORT1_BASE, 8'h01);
        @(posedge clk);
        slp <= 1'b1; host0 <= 8'h01; pmd <= 2'b10;
        fac(8'h01, 8'h00, 8'h00, 8'h00);
        chk(main0, 8'h00);
        chk(main1, 8'h01);
        @(posedge clk);
        host0 <= 8'h81; dev0 <= 8'h20;
        settle;
        chk(main0, 8'hC0);
        rdc(dpit_pkg::OFS_REV, dpit_pkg::REV_DEFAULT);
        @(posedge clk);
        slp <= 1'b0;
        settle;
        chk(main0, 8'hE0);
        rdc(dpit_pkg::OFS_ROOT, 8'h03);
    endtask

    initial begin
        bad_count = 0; checks = 0; ncyc = 0;
        rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 12'h000; sel = 4'h0; wdat = 32'h00000000;
        slp = 1'b0; dev0 = 8'h00; host0 = 8'h00; host1 = 8'h00; pmd = 2'b00;
        c0s = 8'h00; c0c = 8'h00; f1s = 8'h00; f1c = 8'h00;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk(root, 8'h00);
        chk({7'h00, irq_n}, 8'h01);
        reg_table;
        gating;
        events;
        asleep;
        complete_run;
    end
endmodule
